// >>> rtl/kps_result.sv
// Keypad scan result registers, column mask and host scan trigger.
// Assumes a debounced 30-key snapshot and a scan-done pulse on clk_i.
// Function
// - Column mask bits disable detection per column
// - Host mode: no scan until trigger command
// - Trigger starts scan in host mode, clears both results
// - Error bit15, keys third/second/first fields
// - Zero field means no key
// - Up to three keys fill fields in turn
// - First result uses column mask only
// - Second result uses column and key masks
// - Reading a result clears it
// - Key number is (col-1)*5+row
// - Start source bit selects host or key-press
// - Thirty key mask bits affect second only
`timescale 1ns/10ps
module kps_result
    import kps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic scan_start_source_i,
    input wire logic key_press_i,
    input wire logic [kps_pkg::KPS_KEYS-1:0] key_state_i,
    input wire logic scan_done_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [kps_pkg::KPS_ADDR_W-1:0] addr_i,
    input wire logic [kps_pkg::KPS_DATA_W-1:0] wdata_i,
    output logic [kps_pkg::KPS_DATA_W-1:0] rdata_o,
    output logic scan_start_o,
    output logic [kps_pkg::KPS_COLS-1:0] column_detect_mask_o
);
    import kps_pkg::*;

    logic [15:0] col_res_reg, col_res_next;
    logic [15:0] full_res_reg, full_res_next;
    logic [5:0] col_mask_reg, col_mask_next;
    logic [29:0] key_mask_reg, key_mask_next;
    logic [15:0] rdata_reg, rdata_next;
    logic start_reg, start_next;
    logic [29:0] keys_s1_reg, keys_s2_reg;
    logic press_s1_reg, press_s2_reg;
    logic [29:0] col_keys;
    logic [29:0] full_keys;
    logic trig_wr;

    // Column disable bits expanded to key bits, column-major order
    function automatic logic [29:0] col_expand(input logic [5:0] cm);
        logic [29:0] m;
        m = '0;
        for (int c = 0; c < KPS_COLS; c++) begin
            for (int r = 0; r < KPS_ROWS; r++) begin
                m[c*KPS_ROWS+r] = cm[c];
            end
        end
        return m;
    endfunction

    // Packs key numbers low-first; too many keys gives the error word
    function automatic logic [15:0] pack_keys(input logic [29:0] k);
        logic [15:0] w;
        logic [2:0] n;
        logic [3:0] tot;
        w = '0;
        n = '0;
        tot = '0;
        for (int i = 0; i < KPS_KEYS; i++) begin
            if (k[i]) begin
                if (tot != 4'hF) begin
                    tot = tot + 4'h1;
                end
                if (n < 3'(KPS_MAX_REPORT)) begin
                    // Key number i+1 is (col-1)*5+row
                    w[n*KPS_KEY_W +: KPS_KEY_W] = 5'(i + 1);
                    n = n + 3'h1;
                end
            end
        end
        // Exactly four is not called an error; a fourth key is just lost
        if (tot > 4'(KPS_ERR_COUNT)) begin
            w = {1'b1, KPS_ERR_KEY, KPS_ERR_KEY, KPS_ERR_KEY};
        end
        return w;
    endfunction

    assign col_keys = keys_s2_reg & ~col_expand(col_mask_reg);
    assign full_keys = col_keys & ~key_mask_reg;
    assign trig_wr = wr_i && addr_i == KPS_TRIGGER_OFS;

    always_comb begin
        col_res_next = col_res_reg;
        full_res_next = full_res_reg;
        col_mask_next = col_mask_reg;
        key_mask_next = key_mask_reg;
        rdata_next = rdata_reg;
        start_next = 1'b0;
        if (rd_i) begin
            unique case (addr_i)
                KPS_COL_RESULT_OFS: begin
                    rdata_next = col_res_reg;
                    col_res_next = KPS_RESULT_RST;
                end
                KPS_FULL_RESULT_OFS: begin
                    rdata_next = full_res_reg;
                    full_res_next = KPS_RESULT_RST;
                end
                KPS_COL_MASK_OFS: rdata_next = {10'h000, col_mask_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
        if (wr_i) begin
            unique case (addr_i)
                KPS_KEY_MASK_LOW_OFS: key_mask_next[14:0] = wdata_i[14:0];
                KPS_KEY_MASK_HIGH_OFS: key_mask_next[29:15] = wdata_i[14:0];
                KPS_COL_MASK_OFS: col_mask_next = wdata_i[5:0];
                default: ;
            endcase
        end
        // Host mode waits for trigger; key-press mode starts by itself
        if (scan_start_source_i) begin
            start_next = trig_wr;
        end else begin
            start_next = press_s2_reg;
        end
        if (trig_wr) begin
            col_res_next = KPS_RESULT_RST;
            full_res_next = KPS_RESULT_RST;
        end
        // Fresh results win over a same-cycle read clear
        if (scan_done_i) begin
            col_res_next = pack_keys(col_keys);
            full_res_next = pack_keys(full_keys);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            col_res_reg <= KPS_RESULT_RST;
            full_res_reg <= KPS_RESULT_RST;
            col_mask_reg <= KPS_COL_MASK_RST;
            key_mask_reg <= KPS_KEY_MASK_RST;
            rdata_reg <= 16'h0000;
            start_reg <= 1'b0;
            keys_s1_reg <= '0;
            keys_s2_reg <= '0;
            press_s1_reg <= 1'b0;
            press_s2_reg <= 1'b0;
        end else if (clk_en_i) begin
            col_res_reg <= col_res_next;
            full_res_reg <= full_res_next;
            col_mask_reg <= col_mask_next;
            key_mask_reg <= key_mask_next;
            rdata_reg <= rdata_next;
            start_reg <= start_next;
            // Pins come from the matrix, so synchronise first
            keys_s1_reg <= key_state_i;
            keys_s2_reg <= keys_s1_reg;
            press_s1_reg <= key_press_i;
            press_s2_reg <= press_s1_reg;
        end
    end

    assign rdata_o = rdata_reg;
    assign scan_start_o = start_reg;
    assign column_detect_mask_o = col_mask_reg;

    // Start, clear, error, order and range checks; result words are checked whole and field by field
    trig_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && trig_wr && scan_start_source_i |=> scan_start_o)
        else $error("trigger did not start scan");

    host_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_start_source_i && !trig_wr |=> !scan_start_o)
        else $error("scan started without trigger");

    trig_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && trig_wr && !scan_done_i |=>
        col_res_reg == 16'h0000 && full_res_reg == 16'h0000)
        else $error("trigger did not clear results");

    read_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_i && addr_i == KPS_COL_RESULT_OFS && !scan_done_i
        |=> col_res_reg == 16'h0000 && rdata_o == $past(col_res_reg))
        else $error("result read did not clear");

    full_subset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && key_mask_reg == '0 |=>
        full_res_reg == col_res_reg)
        else $error("key mask leaked with no mask set");

    col_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && wr_i && addr_i == KPS_COL_MASK_OFS |=>
        column_detect_mask_o == $past(wdata_i[5:0]))
        else $error("column mask not written");

    err_fields_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        col_res_reg[15] |-> col_res_reg[14:0] == 15'h7FFF)
        else $error("error flag without 31 fields");

    press_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && !scan_start_source_i && press_s2_reg |=> scan_start_o)
        else $error("key press did not start scan");

    mask_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_i && addr_i == KPS_COL_MASK_OFS |=> rdata_o[15:6] == '0)
        else $error("column mask upper bits not zero");

    full_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_i && addr_i == KPS_FULL_RESULT_OFS && !scan_done_i
        |=> full_res_reg == 16'h0000 && rdata_o == $past(full_res_reg))
        else $error("masked result read did not clear");

    unmapped_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_i && addr_i > KPS_COL_MASK_OFS |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");

    // Clock enable low must freeze both results, both masks and the start output
    freeze_state_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(col_res_reg) && $stable(full_res_reg) &&
        $stable(col_mask_reg) && $stable(key_mask_reg) && $stable(scan_start_o))
        else $error("state moved while clock enable low");

    key_low_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && wr_i && addr_i == KPS_KEY_MASK_LOW_OFS |=>
        key_mask_reg[14:0] == $past(wdata_i[14:0]))
        else $error("low key mask not written");

    key_high_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && wr_i && addr_i == KPS_KEY_MASK_HIGH_OFS |=>
        key_mask_reg[29:15] == $past(wdata_i[14:0]))
        else $error("high key mask not written");

    press_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && !scan_start_source_i && !press_s2_reg |=> !scan_start_o)
        else $error("scan started with no key press");

    col_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && col_keys == '0 |=> col_res_reg == '0)
        else $error("result not zero with no key");

    full_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && full_keys == '0 |=> full_res_reg == '0)
        else $error("masked result not zero with all masked");

    col_err_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(col_keys) > KPS_ERR_COUNT
        |=> col_res_reg == 16'hFFFF)
        else $error("too many keys not flagged");

    col_err_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(col_keys) <= KPS_ERR_COUNT
        |=> !col_res_reg[15])
        else $error("error flag with few keys");

    full_err_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(full_keys) > KPS_ERR_COUNT
        |=> full_res_reg == 16'hFFFF)
        else $error("too many masked keys not flagged");

    full_err_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(full_keys) <= KPS_ERR_COUNT
        |=> !full_res_reg[15])
        else $error("masked error flag with few keys");

    col_three_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(col_keys) == 3 |=> col_res_reg[14:10] != '0)
        else $error("third field empty with three keys");

    col_two_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && scan_done_i && $countones(col_keys) == 2 |=>
        col_res_reg[14:10] == '0 && col_res_reg[9:5] != '0)
        else $error("two keys not in first two fields");

    full_err_fields_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        full_res_reg[15] |-> full_res_reg[14:0] == 15'h7FFF)
        else $error("masked error flag without 31 fields");

    col_pack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !col_res_reg[15] && col_res_reg[4:0] == '0 |-> col_res_reg[14:5] == '0)
        else $error("result not packed low");

    full_pack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !full_res_reg[15] && full_res_reg[4:0] == '0 |-> full_res_reg[14:5] == '0)
        else $error("masked result not packed low");

    // Fields rise from first to third, so a swap between filled fields shows at once
    col_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !col_res_reg[15] && col_res_reg[9:5] != '0 |-> col_res_reg[9:5] > col_res_reg[4:0]
        && (col_res_reg[14:10] == '0 || col_res_reg[14:10] > col_res_reg[9:5]))
        else $error("result fields out of order");

    full_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !full_res_reg[15] && full_res_reg[9:5] != '0 |-> full_res_reg[9:5] > full_res_reg[4:0]
        && (full_res_reg[14:10] == '0 || full_res_reg[14:10] > full_res_reg[9:5]))
        else $error("masked result fields out of order");

    col_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !col_res_reg[15] |-> col_res_reg[4:0] <= KPS_KEYS &&
        col_res_reg[9:5] <= KPS_KEYS && col_res_reg[14:10] <= KPS_KEYS)
        else $error("key number beyond thirty");

    full_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !full_res_reg[15] |-> full_res_reg[4:0] <= KPS_KEYS &&
        full_res_reg[9:5] <= KPS_KEYS && full_res_reg[14:10] <= KPS_KEYS)
        else $error("masked key number beyond thirty");

    result_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i && wr_i && !rd_i && !scan_done_i && addr_i == KPS_COL_RESULT_OFS
        |=> $stable(col_res_reg))
        else $error("write changed the result register");
endmodule

// >>> shared/kps_pkg.sv
// Constants for the keypad scan result and column mask block.
// Assumes a 16-bit register port with 6-bit word addresses, page 1 layout.
package kps_pkg;
    localparam int KPS_ADDR_W = 6;
    localparam int KPS_DATA_W = 16;
    localparam int KPS_COLS = 6;
    localparam int KPS_ROWS = 5;
    localparam int KPS_KEYS = 30;
    localparam int KPS_KEY_W = 5;
    localparam int KPS_MAX_REPORT = 3;
    localparam int KPS_ERR_COUNT = 4;
    localparam logic [5:0] KPS_COL_RESULT_OFS = 6'h00;
    localparam logic [5:0] KPS_FULL_RESULT_OFS = 6'h01;
    localparam logic [5:0] KPS_KEY_MASK_LOW_OFS = 6'h01;
    localparam logic [5:0] KPS_KEY_MASK_HIGH_OFS = 6'h02;
    localparam logic [5:0] KPS_COL_MASK_OFS = 6'h03;
    localparam logic [5:0] KPS_TRIGGER_OFS = 6'h04;
    localparam int KPS_ERR_BIT = 15;
    localparam int KPS_THIRD_LSB = 10;
    localparam int KPS_SECOND_LSB = 5;
    localparam int KPS_FIRST_LSB = 0;
    localparam logic [4:0] KPS_ERR_KEY = 5'h1F;
    localparam logic [15:0] KPS_RESULT_RST = 16'h0000;
    localparam logic [5:0] KPS_COL_MASK_RST = 6'h00;
    localparam logic [29:0] KPS_KEY_MASK_RST = 30'h00000000;
endpackage

// >>> verif/kps_keypad_model.sv
// Debounce stand-in: pulses scan done a few cycles after a scan start.
// Assumes start comes from the design on clk_i.
`timescale 1ns/10ps
module kps_keypad_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic done_o
);
    logic start_reg;
    logic [2:0] cnt_reg;
    // Only a start edge begins a scan; a held level is one scan
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_reg <= 1'b0;
            cnt_reg <= 3'h0;
            done_o <= 1'b0;
        end else begin
            start_reg <= start_i;
            done_o <= (cnt_reg == 3'h1);
            cnt_reg <= (start_i && !start_reg) ? 3'h4 :
                (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
        end
    end
endmodule

// >>> verif/tb_kps_result.sv
// Host-side bench for the keypad result block.
// Assumes the keypad model answers each scan start with one done pulse.
`timescale 1ns/10ps
module tb_kps_result;
    import kps_pkg::*;
    logic clk_i = 0, rst_n_i = 0, clk_en_i = 1, src = 1, key_press_i = 0;
    logic scan_done_i, wr_i = 0, rd_i = 0, scan_start_o;
    logic [5:0] addr_i = 0, column_detect_mask_o;
    logic [15:0] wdata_i = 0, rdata_o;
    logic [29:0] key_state_i = 0;
    int n_mismatch = 0, n_tests = 0;
    always #25 clk_i = ~clk_i;
    kps_result i_kps_result (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i), .scan_start_source_i(src),
        .key_press_i(key_press_i), .key_state_i(key_state_i),
        .scan_done_i(scan_done_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .scan_start_o(scan_start_o),
        .column_detect_mask_o(column_detect_mask_o));
    kps_keypad_model i_kps_keypad_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .start_i(scan_start_o), .done_o(scan_done_i));
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1 wr_i = 1;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #1 wr_i = 0;
    endtask
    task rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk_i);
        #1 rd_i = 1;
        addr_i = a;
        @(posedge clk_i);
        #1 rd_i = 0;
        chk("rdata", rdata_o, e);
    endtask
    // Bounded wait; a missing done shows up in the reads that follow
    task wait_done;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_i);
            #1;
            if (scan_done_i === 1'b1)
                break;
        end
        @(posedge clk_i);
        #1;
    endtask
    task scan(input logic [29:0] k);
        key_state_i = k;
        wr(KPS_TRIGGER_OFS, 16'h1234);
        chk("start", {15'h0, scan_start_o}, 16'h0001);
        wait_done;
    endtask
    task wrap_up;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #1 rst_n_i = 1;
        rd(KPS_COL_MASK_OFS, 16'h0000);
        rd(KPS_COL_RESULT_OFS, 16'h0000);
        wr(KPS_COL_MASK_OFS, 16'hFFFF);
        rd(KPS_COL_MASK_OFS, 16'h003F);
        chk("colmask", {10'h0, column_detect_mask_o}, 16'h003F);
        clk_en_i = 0;
        wr(KPS_COL_MASK_OFS, 16'h0000);
        chk("frozen", {10'h0, column_detect_mask_o}, 16'h003F);
        clk_en_i = 1;
        rd(6'h3F, 16'h0000);
        rd(KPS_TRIGGER_OFS, 16'h0000);
        key_press_i = 1;
        repeat (6) begin
            @(posedge clk_i);
            #1 chk("start", {15'h0, scan_start_o}, 16'h0000);
        end
        wr(KPS_COL_MASK_OFS, 16'h0002);
        wr(KPS_KEY_MASK_LOW_OFS, 16'h0001);
        scan(30'h20000841);
        rd(KPS_COL_RESULT_OFS, 16'h7981);
        rd(KPS_FULL_RESULT_OFS, 16'h03CC);
        rd(KPS_COL_RESULT_OFS, 16'h0000);
        rd(KPS_FULL_RESULT_OFS, 16'h0000);
        scan(30'h00000006);
        wr(KPS_TRIGGER_OFS, 16'h0000);
        rd(KPS_COL_RESULT_OFS, 16'h0000);
        rd(KPS_FULL_RESULT_OFS, 16'h0000);
        wr(KPS_KEY_MASK_HIGH_OFS, 16'h4000);
        scan(30'h20000002);
        rd(KPS_COL_RESULT_OFS, 16'h03C2);
        rd(KPS_FULL_RESULT_OFS, 16'h0002);
        wr(KPS_COL_MASK_OFS, 16'h0000);
        key_state_i = 30'h0000003E;
        src = 0;
        @(posedge clk_i);
        #1 chk("start", {15'h0, scan_start_o}, 16'h0001);
        wait_done;
        key_press_i = 0;
        src = 1;
        rd(KPS_COL_RESULT_OFS, 16'hFFFF);
        rd(KPS_FULL_RESULT_OFS, 16'hFFFF);
        wrap_up;
    end
endmodule
